// *** hw/ehc_regs.svh ***
// Constants for the execution halt control block.
// Assumes inclusion by bare name from hw/ files.
`ifndef EHC_REGS_SVH
`define EHC_REGS_SVH
`define EHC_SYNC_STAGES 2
`define EHC_STRAP_WAIT 2'd2
`define EHC_STRAP_CNT_ONE 2'd1
`define EHC_INVAL_LINES 256
`define EHC_SYNC_IDLE_HIGH 1'b1
`define EHC_SYNC_IDLE_LOW 1'b0
`endif

// *** hw/ehc_pkg.sv ***
// Types for the execution halt control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ehc_pkg;
  typedef enum logic [4:0] {
    ST_INVAL = 5'h01,
    ST_RUN = 5'h02,
    ST_HALT = 5'h04,
    ST_STOPGNT = 5'h08,
    ST_CLKSTOP = 5'h10
  } ehc_state_type;
endpackage : ehc_pkg
`default_nettype wire

// *** hw/ehc_sync.sv ***
// Multi-stage synchroniser for one asynchronous pin.
// Assumes a free-running clock and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ehc_regs.svh"
module ehc_sync #(
  parameter int STAGES = `EHC_SYNC_STAGES,
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pin in, synchronised out
  input wire logic pin,
  output logic sync_out
);
  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_nxt;

  // First stage feeds only the second
  always_comb begin
    chain_nxt = {chain_r[STAGES-2:0], pin};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= {STAGES{IDLE}};
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign sync_out = chain_r[STAGES-1];
endmodule : ehc_sync
`default_nettype wire

// *** hw/ehc_core.sv ***
// Execution halt control: run/stop, management interrupt, stop-clock, reset.
// Assumes request pins are asynchronous; core signals share the clock.
`timescale 1ns/1ps
`default_nettype none
`include "ehc_regs.svh"
module ehc_core import ehc_pkg::*; #(
  parameter int INVAL_LINES = `EHC_INVAL_LINES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Asynchronous request and strap pins
  input wire logic run_stop_n,
  input wire logic mgmt_interrupt_request_n,
  input wire logic clock_stop_request_n,
  input wire logic flush_strap_n,
  input wire logic init_strap,
  // Core-side inputs, same clock
  input wire logic instr_boundary,
  input wire logic probe_mode,
  input wire logic high_prio_int_pending,
  input wire logic mgmt_resume,
  input wire logic snoop_request,
  // Execution control outputs
  output logic exec_enable_r,
  output logic halt_ready_r,
  output logic mgmt_mode_active_n_r,
  output logic core_clock_enable_r,
  output logic stop_grant_cycle_r,
  output logic snoop_ack_r,
  // Reset-time outputs
  output logic cache_invalidate_r,
  output logic writeback_inhibit_r,
  output logic tristate_test_r,
  output logic builtin_self_test_r
);
  localparam int IW = (INVAL_LINES > 1) ? $clog2(INVAL_LINES) : 1;
  localparam logic [IW-1:0] INVAL_LAST = IW'(INVAL_LINES - 1);

  logic rs_s, smi_s, stp_s, flush_s, init_s;
  ehc_state_type state_r, state_nxt;
  logic rs_prev_r, rs_prev_nxt, smi_prev_r, smi_prev_nxt;
  logic rs_pend_r, rs_pend_nxt, smi_pend_r, smi_pend_nxt;
  logic [IW-1:0] inval_cnt_r, inval_cnt_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic strap_done_r, strap_done_nxt;
  logic exec_nxt, halt_nxt, mgmt_n_nxt, clk_en_nxt, grant_nxt, snoop_nxt;
  logic inval_nxt, wb_inh_nxt, tri_nxt, builtin_self_test_nxt;
  logic rs_fall, rs_rise, smi_fall, take_smi, take_rs, take_stp;

  // Pull-up pins idle high, init idles low
  ehc_sync #(.STAGES(`EHC_SYNC_STAGES), .IDLE(`EHC_SYNC_IDLE_HIGH)) u_rs (
    .clock(clock), .reset_n(reset_n), .pin(run_stop_n), .sync_out(rs_s));
  ehc_sync #(.STAGES(`EHC_SYNC_STAGES), .IDLE(`EHC_SYNC_IDLE_HIGH)) u_smi (
    .clock(clock), .reset_n(reset_n), .pin(mgmt_interrupt_request_n), .sync_out(smi_s));
  ehc_sync #(.STAGES(`EHC_SYNC_STAGES), .IDLE(`EHC_SYNC_IDLE_HIGH)) u_stp (
    .clock(clock), .reset_n(reset_n), .pin(clock_stop_request_n), .sync_out(stp_s));
  ehc_sync #(.STAGES(`EHC_SYNC_STAGES), .IDLE(`EHC_SYNC_IDLE_HIGH)) u_flush (
    .clock(clock), .reset_n(reset_n), .pin(flush_strap_n), .sync_out(flush_s));
  ehc_sync #(.STAGES(`EHC_SYNC_STAGES), .IDLE(`EHC_SYNC_IDLE_LOW)) u_init (
    .clock(clock), .reset_n(reset_n), .pin(init_strap), .sync_out(init_s));

  // Edges for run/stop and management requests; a held low level never re-arms them
  assign rs_fall = rs_prev_r & ~rs_s;
  assign rs_rise = ~rs_prev_r & rs_s;
  assign smi_fall = smi_prev_r & ~smi_s;
  assign take_smi = (state_r == ST_RUN) & instr_boundary & smi_pend_r;
  assign take_rs = (state_r == ST_RUN) & instr_boundary & ~smi_pend_r & rs_pend_r;
  assign take_stp = (state_r == ST_RUN) & instr_boundary & ~smi_pend_r & ~rs_pend_r
                    & ~stp_s & ~high_prio_int_pending;

  always_comb begin
    state_nxt = state_r;
    rs_prev_nxt = rs_s;
    smi_prev_nxt = smi_s;
    // Set wins over the clear of the same cycle
    rs_pend_nxt = (rs_pend_r & ~take_rs) | rs_fall;
    smi_pend_nxt = (smi_pend_r & ~take_smi) | smi_fall;
    inval_cnt_nxt = inval_cnt_r;
    strap_cnt_nxt = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    tri_nxt = tristate_test_r;
    builtin_self_test_nxt = 1'b0;
    grant_nxt = 1'b0;
    snoop_nxt = snoop_request;
    mgmt_n_nxt = mgmt_mode_active_n_r;
    // Straps read once the synchroniser holds post-release values
    if (!strap_done_r) begin
      strap_cnt_nxt = strap_cnt_r + `EHC_STRAP_CNT_ONE;
      if (strap_cnt_r == `EHC_STRAP_WAIT) begin
        strap_done_nxt = 1'b1;
        tri_nxt = ~flush_s;
        builtin_self_test_nxt = init_s;
      end
    end
    if (take_smi) begin
      mgmt_n_nxt = 1'b0;
    end else if (mgmt_resume) begin
      mgmt_n_nxt = 1'b1;
    end
    case (state_r)
      ST_INVAL: begin
        inval_cnt_nxt = inval_cnt_r + IW'(1);
        if (inval_cnt_r == INVAL_LAST) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (take_rs) begin
          state_nxt = ST_HALT;
        end else if (take_stp) begin
          state_nxt = ST_STOPGNT;
        end
      end
      ST_HALT: begin
        if (rs_rise) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOPGNT: begin
        grant_nxt = 1'b1;
        state_nxt = ST_CLKSTOP;
      end
      ST_CLKSTOP: begin
        if (stp_s) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_INVAL;
      end
    endcase
    exec_nxt = (state_nxt == ST_RUN);
    halt_nxt = (state_nxt == ST_HALT) | probe_mode;
    clk_en_nxt = (state_nxt != ST_CLKSTOP);
    inval_nxt = (state_nxt == ST_INVAL);
    // Modified lines die with the invalidate, no bus cycles
    wb_inh_nxt = (state_nxt == ST_INVAL);
  end

  // Reset clears all pending requests and the mode flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_INVAL;
      rs_prev_r <= 1'b1;
      smi_prev_r <= 1'b1;
      rs_pend_r <= 1'b0;
      smi_pend_r <= 1'b0;
      inval_cnt_r <= '0;
      strap_cnt_r <= 2'd0;
      strap_done_r <= 1'b0;
      exec_enable_r <= 1'b0;
      halt_ready_r <= 1'b0;
      mgmt_mode_active_n_r <= 1'b1;
      core_clock_enable_r <= 1'b1;
      stop_grant_cycle_r <= 1'b0;
      snoop_ack_r <= 1'b0;
      cache_invalidate_r <= 1'b1;
      writeback_inhibit_r <= 1'b1;
      tristate_test_r <= 1'b0;
      builtin_self_test_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rs_prev_r <= rs_prev_nxt;
      smi_prev_r <= smi_prev_nxt;
      rs_pend_r <= rs_pend_nxt;
      smi_pend_r <= smi_pend_nxt;
      inval_cnt_r <= inval_cnt_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
      exec_enable_r <= exec_nxt;
      halt_ready_r <= halt_nxt;
      mgmt_mode_active_n_r <= mgmt_n_nxt;
      core_clock_enable_r <= clk_en_nxt;
      stop_grant_cycle_r <= grant_nxt;
      snoop_ack_r <= snoop_nxt;
      cache_invalidate_r <= inval_nxt;
      writeback_inhibit_r <= wb_inh_nxt;
      tristate_test_r <= tri_nxt;
      builtin_self_test_r <= builtin_self_test_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence grant_seq;
    ((state_r == ST_STOPGNT) && !exec_enable_r)
      ##1 (stop_grant_cycle_r && (state_r == ST_CLKSTOP) && !core_clock_enable_r);
  endsequence

  sequence rs_halt_seq;
    (state_r == ST_HALT) && halt_ready_r && !exec_enable_r;
  endsequence

  stop_grant_cycle_a: assert property (take_stp |=> grant_seq)
    else $error("stop grant cycle not issued before clock stop");
  run_stop_halt_a: assert property (take_rs |=> rs_halt_seq)
    else $error("run/stop edge did not halt execution");
  level_no_halt_a: assert property ((state_r == ST_RUN) && !rs_pend_r && !rs_fall |=> state_r != ST_HALT)
    else $error("halt entered without a run/stop edge");
  smi_latch_a: assert property (smi_fall && !take_smi |=> smi_pend_r)
    else $error("management request edge not latched");
  // A fresh edge in the take cycle stays pending, so it is left out here
  mgmt_enter_a: assert property (take_smi && !smi_fall |=> !mgmt_mode_active_n_r && !smi_pend_r)
    else $error("management mode not entered");
  mgmt_hold_a: assert property (!mgmt_mode_active_n_r && !mgmt_resume |=> !mgmt_mode_active_n_r)
    else $error("management active output dropped early");
  clock_stop_a: assert property ((state_r == ST_CLKSTOP) |-> !core_clock_enable_r && !exec_enable_r)
    else $error("core clock running while stopped");
  prio_defer_a: assert property ((state_r == ST_RUN) && instr_boundary && !stp_s && high_prio_int_pending
                                 |=> state_r != ST_STOPGNT)
    else $error("stop clock taken over higher priority interrupt");
  snoop_serve_a: assert property (snoop_request |=> snoop_ack_r)
    else $error("snoop not serviced");
  inval_no_wb_a: assert property (cache_invalidate_r |-> writeback_inhibit_r && !exec_enable_r)
    else $error("write-back allowed during reset invalidate");
  inval_len_a: assert property ((state_r == ST_INVAL) && (inval_cnt_r == INVAL_LAST) |=> state_r == ST_RUN)
    else $error("invalidate sweep length wrong");
endmodule : ehc_core
`default_nettype wire

// *** bench/ehc_partner.sv ***
// Behavioural system logic that drives the asynchronous request and strap pins.
// Assumes the bench calls set_pins; every pin idles high except the init strap.
`timescale 1ns/1ps
`default_nettype none
module ehc_partner (
  // Clock
  input wire logic clock,
  // Request and strap pins
  output var logic run_stop_n,
  output var logic mgmt_interrupt_request_n,
  output var logic clock_stop_request_n,
  output var logic flush_strap_n,
  output var logic init_strap
);
  initial begin
    {run_stop_n, mgmt_interrupt_request_n, clock_stop_request_n, flush_strap_n, init_strap} = 5'h1e;
  end
  // Falling edge only, so a change never lands on the core's sampling edge
  task automatic set_pins(input logic [4:0] v);
    @(negedge clock);
    {run_stop_n, mgmt_interrupt_request_n, clock_stop_request_n, flush_strap_n, init_strap} <= v;
  endtask : set_pins
endmodule : ehc_partner
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the execution halt control core.
// Assumes ehc_pkg, ehc_core and ehc_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock;
  logic reset_n;
  logic instr_boundary, probe_mode, high_prio_int_pending;
  logic mgmt_resume, snoop_request;
  logic run_stop_n, mgmt_interrupt_request_n, clock_stop_request_n, flush_strap_n, init_strap;
  logic exec_enable_r, halt_ready_r, mgmt_mode_active_n_r, core_clock_enable_r, stop_grant_cycle_r;
  logic snoop_ack_r, cache_invalidate_r, writeback_inhibit_r, tristate_test_r, builtin_self_test_r;
  logic seen;
  int fails = 0;
  int check_count = 0;
  int i;
  always #5 clock = ~clock;
  ehc_partner i_partner (.clock(clock), .run_stop_n(run_stop_n),
    .mgmt_interrupt_request_n(mgmt_interrupt_request_n), .clock_stop_request_n(clock_stop_request_n),
    .flush_strap_n(flush_strap_n), .init_strap(init_strap));
  // Short sweep keeps the run brief
  ehc_core #(.INVAL_LINES(4)) i_dut (.clock(clock), .reset_n(reset_n), .run_stop_n(run_stop_n),
    .mgmt_interrupt_request_n(mgmt_interrupt_request_n), .clock_stop_request_n(clock_stop_request_n),
    .flush_strap_n(flush_strap_n), .init_strap(init_strap), .instr_boundary(instr_boundary),
    .probe_mode(probe_mode), .high_prio_int_pending(high_prio_int_pending), .mgmt_resume(mgmt_resume),
    .snoop_request(snoop_request), .exec_enable_r(exec_enable_r), .halt_ready_r(halt_ready_r),
    .mgmt_mode_active_n_r(mgmt_mode_active_n_r), .core_clock_enable_r(core_clock_enable_r),
    .stop_grant_cycle_r(stop_grant_cycle_r), .snoop_ack_r(snoop_ack_r),
    .cache_invalidate_r(cache_invalidate_r), .writeback_inhibit_r(writeback_inhibit_r),
    .tristate_test_r(tristate_test_r), .builtin_self_test_r(builtin_self_test_r));
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic do_reset(input logic fl_n, input logic ini);
    i_partner.set_pins({3'b111, fl_n, ini});
    reset_n <= 1'b0;
    cyc(16);
    chk(cache_invalidate_r === 1'b1 && writeback_inhibit_r === 1'b1, "no sweep in reset");
    chk(exec_enable_r === 1'b0 && mgmt_mode_active_n_r === 1'b1, "reset state");
    chk(core_clock_enable_r === 1'b1, "clock off in reset");
    reset_n <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 12 && exec_enable_r !== 1'b1; i++) begin
      cyc(1);
      seen |= (builtin_self_test_r === 1'b1);
    end
    chk(i == 4 && cache_invalidate_r === 1'b0 && writeback_inhibit_r === 1'b0, "sweep length");
    chk(seen === ini && tristate_test_r === ~fl_n, "strap decode");
    i_partner.set_pins(5'h1e);
    $display("reset test done");
  endtask : do_reset
  task automatic test_run_stop;
    i_partner.set_pins(5'h0e);
    cyc(8);
    chk(exec_enable_r === 1'b1 && halt_ready_r === 1'b0, "halt off boundary");
    instr_boundary <= 1'b1;
    cyc(2);
    chk(exec_enable_r === 1'b0 && halt_ready_r === 1'b1, "no halt");
    cyc(10);
    chk(halt_ready_r === 1'b1, "idle left while low");
    i_partner.set_pins(5'h1e);
    cyc(6);
    chk(exec_enable_r === 1'b1 && halt_ready_r === 1'b0, "no resume");
    cyc(10);
    chk(exec_enable_r === 1'b1, "halt on level");
    instr_boundary <= 1'b0;
    $display("run stop test done");
  endtask : test_run_stop
  task automatic test_mgmt;
    i_partner.set_pins(5'h16);
    cyc(3);
    i_partner.set_pins(5'h1e);
    cyc(8);
    chk(mgmt_mode_active_n_r === 1'b1, "entry off boundary");
    instr_boundary <= 1'b1;
    cyc(2);
    chk(mgmt_mode_active_n_r === 1'b0, "latched request lost");
    instr_boundary <= 1'b0;
    cyc(12);
    chk(mgmt_mode_active_n_r === 1'b0 && exec_enable_r === 1'b1, "mode dropped");
    mgmt_resume <= 1'b1;
    cyc(1);
    mgmt_resume <= 1'b0;
    cyc(2);
    chk(mgmt_mode_active_n_r === 1'b1, "mode not left");
    $display("management test done");
  endtask : test_mgmt
  task automatic test_stop_clock;
    high_prio_int_pending <= 1'b1;
    instr_boundary <= 1'b1;
    i_partner.set_pins(5'h1a);
    cyc(10);
    chk(exec_enable_r === 1'b1 && core_clock_enable_r === 1'b1, "stop over priority");
    high_prio_int_pending <= 1'b0;
    seen = 1'b0;
    for (i = 0; i < 10 && core_clock_enable_r !== 1'b0; i++) begin
      cyc(1);
      seen |= (stop_grant_cycle_r === 1'b1);
    end
    chk(seen === 1'b1 && exec_enable_r === 1'b0, "no grant cycle");
    chk(core_clock_enable_r === 1'b0, "clock not stopped");
    snoop_request <= 1'b1;
    cyc(1);
    chk(snoop_ack_r === 1'b1, "snoop ignored");
    snoop_request <= 1'b0;
    instr_boundary <= 1'b0;
    i_partner.set_pins(5'h1e);
    cyc(5);
    chk(core_clock_enable_r === 1'b1 && exec_enable_r === 1'b1, "no wake");
    $display("stop clock test done");
  endtask : test_stop_clock
  task automatic test_probe_override;
    probe_mode <= 1'b1;
    cyc(2);
    chk(halt_ready_r === 1'b1, "probe not flagged");
    probe_mode <= 1'b0;
    i_partner.set_pins(5'h16);
    cyc(4);
    // Request left pending, then wiped by a third reset
    do_reset(1'b1, 1'b0);
    instr_boundary <= 1'b1;
    cyc(4);
    chk(mgmt_mode_active_n_r === 1'b1 && halt_ready_r === 1'b0, "pending survived reset");
    instr_boundary <= 1'b0;
    $display("probe and override test done");
  endtask : test_probe_override
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    instr_boundary = 1'b0;
    probe_mode = 1'b0;
    high_prio_int_pending = 1'b0;
    mgmt_resume = 1'b0;
    snoop_request = 1'b0;
    do_reset(1'b0, 1'b1);
    do_reset(1'b1, 1'b0);
    test_run_stop;
    test_mgmt;
    test_stop_clock;
    test_probe_override;
    final_report;
  end
  // Tests take well under a thousand cycles
  initial begin
    #100000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    final_report;
  end
endmodule : tb_top
`default_nettype wire
